// ---- src/spep_defs.vh ----
// Constants shared by the serial nonvolatile memory command and protection front end.
`ifndef SPEP_DEFS_VH
`define SPEP_DEFS_VH

// Instruction codes with bit 3 cleared; bit 3 is masked before comparison.
`define SPEP_OPC_MASK 8'hf7
`define SPEP_OPC_SET_LATCH 8'h06
`define SPEP_OPC_CLEAR_LATCH 8'h04
`define SPEP_OPC_STATUS_READ 8'h05
`define SPEP_OPC_STATUS_WRITE 8'h01
`define SPEP_OPC_ARRAY_READ 8'h03
`define SPEP_OPC_ARRAY_WRITE 8'h02

// Status register field positions.
`define SPEP_ST_BUSY 0
`define SPEP_ST_LATCH 1
`define SPEP_ST_LEVEL_LO 2
`define SPEP_ST_LEVEL_HI 4
`define SPEP_ST_ARM 7

// Reset values: latch clear at power-up, protect level and arm bit ship as zero.
`define SPEP_RST_LATCH 1'b0
`define SPEP_RST_LEVEL 3'h0
`define SPEP_RST_ARM 1'b0
`define SPEP_STATUS_BUSY_VIEW 8'hff

// Array geometry.
`define SPEP_ADDR_W 16
`define SPEP_PAGE_BITS 7

// Timing: self-timed write cycle converted to core clock cycles, rounded down.
`define SPEP_CLK_PERIOD_NS 24'h000064
`define SPEP_WRITE_TIME_NS 24'h4c4b40
`define SPEP_WRITE_CYCLES (`SPEP_WRITE_TIME_NS / `SPEP_CLK_PERIOD_NS)

`endif

// ---- src/spep_top.v ----
// Serial slave front end with status register, write latch and block protection.
`timescale 1ns/1ns
`include "spep_defs.vh"
module spep_top #(
  parameter [23:0] WRITE_CYCLES = `SPEP_WRITE_CYCLES
) (
  input wire CORE_CLK, // Core clock, 10 MHz.
  input wire SYS_RST, // Synchronous reset, active high.
  input wire CS_N, // Chip select from the master, active low.
  input wire SCK, // Serial clock from the master.
  input wire SI, // Serial data in.
  input wire HOLD_N, // Suspend input, active low.
  input wire WP_N, // Write protect input, active low.
  output wire SO, // Serial data out.
  output wire SO_OE, // High while SO is driven.
  output wire [15:0] ARRAY_ADDR, // Array byte address for reads and page strobes.
  input wire [7:0] ARRAY_RD_DATA, // Array data at ARRAY_ADDR.
  output wire ARRAY_WR_STB, // One-cycle strobe of an accepted page byte.
  output wire [7:0] ARRAY_WR_DATA, // Byte that goes with ARRAY_WR_STB.
  output wire WRITE_START, // One-cycle pulse launching the array write cycle.
  output wire BUSY // High during the internal write cycle.
);

  localparam [5:0] ST_OPC = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_WDATA = 6'h04;
  localparam [5:0] ST_RDATA = 6'h08;
  localparam [5:0] ST_SWDATA = 6'h10;
  localparam [5:0] ST_IGNORE = 6'h20;

  reg cs_s1_reg, cs_s2_reg, cs_prev_reg;
  reg sck_s1_reg, sck_s2_reg, sck_prev_reg;
  reg si_s1_reg, si_s2_reg;
  reg hold_s1_reg, hold_s2_reg;
  reg wp_s1_reg, wp_s2_reg;
  reg frame_reg;
  reg [5:0] state_reg;
  reg [2:0] rx_cnt_reg;
  reg [6:0] rx_shift_reg;
  reg addr_byte_reg;
  reg is_write_reg;
  reg src_status_reg;
  reg load_reg;
  reg [7:0] tx_reg;
  reg [2:0] tx_idx_reg;
  reg so_reg;
  reg [15:0] addr_reg;
  reg [7:0] wr_data_reg;
  reg wr_stb_reg;
  reg wr_any_reg;
  reg start_reg;
  reg pend_set_reg, pend_clr_reg, pend_sw_reg;
  reg [7:0] sw_data_reg;
  reg stat_pend_reg;
  reg [7:0] stat_val_reg;
  reg latch_reg;
  reg [2:0] level_reg;
  reg arm_reg;
  reg busy_reg;
  reg [23:0] busy_cnt_reg;

  // Tests whether a byte address lies in the range selected by the level bits.
  function in_protected;
    input [15:0] a;
    input [1:0] lvl;
    begin
      case (lvl)
        2'b00: in_protected = 1'b0;
        2'b01: in_protected = (a[15:14] == 2'b11);
        2'b10: in_protected = a[15];
        2'b11: in_protected = 1'b1;
        default: in_protected = 1'b1;
      endcase
    end
  endfunction

  wire cs_rise = cs_s2_reg & ~cs_prev_reg;
  wire cs_fall = ~cs_s2_reg & cs_prev_reg;
  wire sck_rise = sck_s2_reg & ~sck_prev_reg;
  wire sck_fall = ~sck_s2_reg & sck_prev_reg;
  // Suspend gates both clock edges; with HOLD_N high this term is true whenever a frame is open and chip select is low.
  wire active = frame_reg & ~cs_s2_reg & hold_s2_reg;
  wire byte_done = active & sck_rise & (rx_cnt_reg == 3'h7);
  wire [7:0] rx_byte = {rx_shift_reg, si_s2_reg};
  wire [7:0] opc = rx_byte & `SPEP_OPC_MASK;
  wire hw_protect = arm_reg & ~wp_s2_reg;
  wire [7:0] status_view = busy_reg ? `SPEP_STATUS_BUSY_VIEW :
    {arm_reg, 2'b00, level_reg, latch_reg, 1'b0};
  wire [15:0] page_next = {addr_reg[15:`SPEP_PAGE_BITS], addr_reg[6:0] + 7'h01};
  wire byte_ok = latch_reg & ~in_protected(addr_reg, level_reg[1:0]);

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cs_s1_reg <= 1'b0;
      cs_s2_reg <= 1'b0;
      cs_prev_reg <= 1'b0;
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
      hold_s1_reg <= 1'b1;
      hold_s2_reg <= 1'b1;
      wp_s1_reg <= 1'b1;
      wp_s2_reg <= 1'b1;
      frame_reg <= 1'b0;
      state_reg <= ST_OPC;
      rx_cnt_reg <= 3'h0;
      rx_shift_reg <= 7'h00;
      addr_byte_reg <= 1'b0;
      is_write_reg <= 1'b0;
      src_status_reg <= 1'b0;
      load_reg <= 1'b0;
      tx_reg <= 8'h00;
      tx_idx_reg <= 3'h0;
      so_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wr_data_reg <= 8'h00;
      wr_stb_reg <= 1'b0;
      wr_any_reg <= 1'b0;
      start_reg <= 1'b0;
      pend_set_reg <= 1'b0;
      pend_clr_reg <= 1'b0;
      pend_sw_reg <= 1'b0;
      sw_data_reg <= 8'h00;
      stat_pend_reg <= 1'b0;
      stat_val_reg <= 8'h00;
      latch_reg <= `SPEP_RST_LATCH;
      level_reg <= `SPEP_RST_LEVEL;
      arm_reg <= `SPEP_RST_ARM;
      busy_reg <= 1'b0;
      busy_cnt_reg <= 24'h000000;
    end else begin
      // Two flip-flops on each of CS_N, SCK, SI, HOLD_N and WP_N before any logic looks at it.
      cs_s1_reg <= CS_N;
      cs_s2_reg <= cs_s1_reg;
      cs_prev_reg <= cs_s2_reg;
      sck_s1_reg <= SCK;
      sck_s2_reg <= sck_s1_reg;
      sck_prev_reg <= sck_s2_reg;
      si_s1_reg <= SI;
      si_s2_reg <= si_s1_reg;
      hold_s1_reg <= HOLD_N;
      hold_s2_reg <= hold_s1_reg;
      wp_s1_reg <= WP_N;
      wp_s2_reg <= wp_s1_reg;
      wr_stb_reg <= 1'b0;
      start_reg <= 1'b0;

      // The next output byte is fetched one cycle after its address is set.
      if (load_reg) begin
        tx_reg <= src_status_reg ? status_view : ARRAY_RD_DATA;
        load_reg <= 1'b0;
      end

      // Self-timed write; the latch drops and a staged status value lands at its end.
      if (busy_reg) begin
        if (busy_cnt_reg == WRITE_CYCLES - 24'h000001) begin
          busy_reg <= 1'b0;
          busy_cnt_reg <= 24'h000000;
          latch_reg <= 1'b0;
          stat_pend_reg <= 1'b0;
          if (stat_pend_reg) begin
            level_reg <= stat_val_reg[`SPEP_ST_LEVEL_HI:`SPEP_ST_LEVEL_LO];
            arm_reg <= stat_val_reg[`SPEP_ST_ARM];
          end
        end else begin
          busy_cnt_reg <= busy_cnt_reg + 24'h000001;
        end
      end

      // Chip select rising executes what the closed frame fully received.
      if (cs_rise && frame_reg) begin
        if (pend_set_reg) begin
          latch_reg <= 1'b1;
        end
        if (pend_clr_reg) begin
          latch_reg <= 1'b0;
        end
        // Protection covers the arm bit, so a one-to-zero change under a low pin is refused.
        if (pend_sw_reg && latch_reg && !hw_protect) begin
          busy_reg <= 1'b1;
          stat_pend_reg <= 1'b1;
          stat_val_reg <= sw_data_reg;
        end
        if (wr_any_reg) begin
          busy_reg <= 1'b1;
          start_reg <= 1'b1;
        end
      end

      if (cs_s2_reg) begin
        frame_reg <= 1'b0;
        state_reg <= ST_OPC;
        rx_cnt_reg <= 3'h0;
        addr_byte_reg <= 1'b0;
        tx_idx_reg <= 3'h0;
        wr_any_reg <= 1'b0;
        pend_set_reg <= 1'b0;
        pend_clr_reg <= 1'b0;
        pend_sw_reg <= 1'b0;
      end else if (cs_fall) begin
        frame_reg <= 1'b1;
      end else if (active && sck_rise) begin
        rx_cnt_reg <= rx_cnt_reg + 3'h1;
        rx_shift_reg <= rx_byte[6:0];
        if (byte_done) begin
          case (state_reg)
            ST_OPC: begin
              if (busy_reg && opc != `SPEP_OPC_STATUS_READ) begin
                state_reg <= ST_IGNORE;
              end else begin
                case (opc)
                  `SPEP_OPC_SET_LATCH: begin
                    pend_set_reg <= 1'b1;
                    state_reg <= ST_IGNORE;
                  end
                  `SPEP_OPC_CLEAR_LATCH: begin
                    pend_clr_reg <= 1'b1;
                    state_reg <= ST_IGNORE;
                  end
                  `SPEP_OPC_STATUS_READ: begin
                    src_status_reg <= 1'b1;
                    load_reg <= 1'b1;
                    state_reg <= ST_RDATA;
                  end
                  `SPEP_OPC_STATUS_WRITE: begin
                    state_reg <= ST_SWDATA;
                  end
                  `SPEP_OPC_ARRAY_READ: begin
                    is_write_reg <= 1'b0;
                    state_reg <= ST_ADDR;
                  end
                  `SPEP_OPC_ARRAY_WRITE: begin
                    is_write_reg <= 1'b1;
                    state_reg <= ST_ADDR;
                  end
                  default: begin
                    state_reg <= ST_IGNORE;
                  end
                endcase
              end
            end
            ST_ADDR: begin
              addr_reg <= {addr_reg[7:0], rx_byte};
              addr_byte_reg <= 1'b1;
              if (addr_byte_reg) begin
                if (is_write_reg) begin
                  state_reg <= ST_WDATA;
                end else begin
                  src_status_reg <= 1'b0;
                  load_reg <= 1'b1;
                  state_reg <= ST_RDATA;
                end
              end
            end
            ST_WDATA: begin
              addr_reg <= page_next;
              if (byte_ok) begin
                wr_stb_reg <= 1'b1;
                wr_data_reg <= rx_byte;
                wr_any_reg <= 1'b1;
              end
            end
            ST_RDATA: begin
              if (!src_status_reg) begin
                addr_reg <= addr_reg + 16'h0001;
              end
              load_reg <= 1'b1;
            end
            ST_SWDATA: begin
              sw_data_reg <= rx_byte;
              pend_sw_reg <= 1'b1;
              state_reg <= ST_IGNORE;
            end
            ST_IGNORE: begin
              state_reg <= ST_IGNORE;
            end
            default: begin
              state_reg <= ST_IGNORE;
            end
          endcase
        end
      end else if (active && sck_fall && state_reg == ST_RDATA) begin
        so_reg <= tx_reg[3'h7 - tx_idx_reg];
        tx_idx_reg <= tx_idx_reg + 3'h1;
      end
    end
  end

  assign SO = so_reg;
  // Output undriven outside a frame, under suspend and outside the output phase.
  assign SO_OE = active & (state_reg == ST_RDATA);
  assign ARRAY_ADDR = addr_reg;
  assign ARRAY_WR_STB = wr_stb_reg;
  assign ARRAY_WR_DATA = wr_data_reg;
  assign WRITE_START = start_reg;
  assign BUSY = busy_reg;

endmodule // spep_top

// ---- dv/spep_top_sva.sv ----
// Port-level assertions for the serial protection front end.
`timescale 1ns/1ns
module spep_top_sva #(
  parameter [23:0] WRITE_CYCLES = 24'h000014
) (
  input wire CORE_CLK, // Clock.
  input wire SYS_RST, // Reset.
  input wire CS_N, // Chip select.
  input wire SCK, // Serial clock.
  input wire HOLD_N, // Suspend.
  input wire SO, // Serial out.
  input wire SO_OE, // Out enable.
  input wire [15:0] ARRAY_ADDR, // Address.
  input wire ARRAY_WR_STB, // Byte strobe.
  input wire WRITE_START, // Launch.
  input wire BUSY // Write cycle.
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic [23:0] busy_cnt_reg;
  logic [15:0] addr_prev_reg;
  always @(posedge CORE_CLK) begin
    busy_cnt_reg <= (SYS_RST || !BUSY) ? 24'h0 : busy_cnt_reg + 24'h1;
    addr_prev_reg <= ARRAY_ADDR;
  end
  a_idle_float: assert property (CS_N [*5] |-> !SO_OE) else $error("output on while deselected");
  a_hold_mute: assert property (!HOLD_N [*4] |-> !SO_OE) else $error("output on while held");
  a_start_busy: assert property (WRITE_START |=> BUSY && !WRITE_START) else $error("launch without busy");
  a_busy_cs: assert property ($rose(BUSY) |-> CS_N && $past(CS_N, 2)) else $error("busy inside frame");
  a_busy_len: assert property ($fell(BUSY) |-> busy_cnt_reg == WRITE_CYCLES) else $error("busy length");
  a_busy_quiet: assert property (BUSY |-> !ARRAY_WR_STB) else $error("byte taken while busy");
  a_stb_gap: assert property (ARRAY_WR_STB |-> !CS_N ##1 !ARRAY_WR_STB [*8]) else $error("strobe spacing");
  a_page_wrap: assert property (ARRAY_WR_STB |-> ARRAY_ADDR == {addr_prev_reg[15:7], addr_prev_reg[6:0] + 7'h1})
    else $error("address left page");
  a_so_fall: assert property ($changed(SO) |-> !SCK) else $error("output moved with clock high");
endmodule // spep_top_sva
bind spep_top spep_top_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .CS_N(CS_N), .SCK(SCK), .HOLD_N(HOLD_N), .SO(SO), .SO_OE(SO_OE), .ARRAY_ADDR(ARRAY_ADDR),
  .ARRAY_WR_STB(ARRAY_WR_STB), .WRITE_START(WRITE_START), .BUSY(BUSY));

// ---- dv/spep_master.sv ----
// Model of the bus master that drives the serial link in mode 0 or mode 3.
`timescale 1ns/1ns
module spep_master (
  output logic cs_n, // Chip select.
  output logic sck, // Clock, low outside frames except in mode 3, where it idles high.
  output logic si, // Data out.
  output logic hold_n, // Suspend.
  input wire so // Data in.
);
  logic m3 = 1'b0;
  initial {cs_n, sck, si, hold_n} = 4'h9;
  // Changes the idle clock level; only called while chip select is high.
  task mode3(input logic v);
    sck = v;
    m3 = v;
    #800;
  endtask
  task open();
    cs_n = 1'b0;
    #400;
  endtask
  task close();
    #400 cs_n = 1'b1;
    si = ~si;
    #800;
  endtask
  task xfer(input logic [7:0] tx, output logic [7:0] rx, input int hb = -1);
    for (int i = 7; i >= 0; i--) begin
      if (i == hb) begin
        // Suspend moves well inside the low clock phase, apart from any clock edge.
        #200 hold_n = 1'b0;
        repeat (3) begin
          #400 sck = 1'b1;
          si = ~si;
          #400 sck = 1'b0;
        end
        #200 hold_n = 1'b1;
      end
      if (m3) sck = 1'b0;
      si = tx[i];
      #400 sck = 1'b1;
      #200 rx[i] = so;
      #200 if (!m3) sck = 1'b0;
    end
  endtask
endmodule // spep_master

// ---- dv/spep_top_tb.sv ----
// Self-checking bench for the serial protection front end.
`timescale 1ns/1ns
module spep_top_tb;
  localparam int WC = 400;
  logic clk, rst, wp_n;
  logic [7:0] rx;
  logic [15:0] saddr;
  logic [7:0] sdata;
  logic [15:0] pa [3] = '{16'h7fff, 16'hbfff, 16'hc000};
  int n_fail = 0, cmp_count = 0, n_stb = 0, cyc = 0, s, n_go = 0, g;
  wire cs_n, sck, si, hold_n, so, so_oe, stb, wstart, busy;
  // The released output line reads high through its pull-up.
  wire so_line = so_oe ? so : 1'b1;
  wire [15:0] addr;
  wire [7:0] wdata;
  function automatic logic [7:0] rd(input logic [15:0] a);
    return a[7:0] + a[15:8] + 8'h11;
  endfunction
  spep_top #(.WRITE_CYCLES(24'(WC))) uut (.CORE_CLK(clk), .SYS_RST(rst), .CS_N(cs_n), .SCK(sck), .SI(si),
    .HOLD_N(hold_n), .WP_N(wp_n), .SO(so), .SO_OE(so_oe), .ARRAY_ADDR(addr), .ARRAY_RD_DATA(rd(addr)),
    .ARRAY_WR_STB(stb), .ARRAY_WR_DATA(wdata), .WRITE_START(wstart), .BUSY(busy));
  spep_master m (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so_line));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stb === 1'b1) begin
      n_stb <= n_stb + 1;
      saddr <= {addr[15:7], addr[6:0] - 7'h1};
      sdata <= wdata;
    end
    if (wstart === 1'b1) begin
      n_go <= n_go + 1;
    end
    if (cyc == 40000) begin
      n_fail++;
      end_of_test();
    end
  end
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cmd(input logic [7:0] op, input logic [15:0] a, input int na, input logic [7:0] d, input int nd);
    m.open();
    m.xfer(op, rx);
    for (int i = na; i > 0; i--) m.xfer(a[8*i-1 -: 8], rx);
    for (int i = 0; i < nd; i++) m.xfer(d + 8'(i), rx);
    m.close();
  endtask
  task status_read_cmd(input logic [7:0] op, input logic [7:0] exp);
    cmd(op, '0, 0, '0, 1);
    chk("status", exp, rx);
  endtask
  task wait_idle();
    for (int i = 0; i < WC + 50; i++) begin
      @(posedge clk);
      #1;
      if (busy === 1'b0) break;
    end
  endtask
  task t_status();
    status_read_cmd(8'h05, 8'h00);
    cmd(8'h0e, '0, 0, '0, 0);
    status_read_cmd(8'h0d, 8'h02);
    cmd(8'h0c, '0, 0, '0, 0);
    status_read_cmd(8'h05, 8'h00);
    cmd(8'h07, '0, 0, 8'h06, 1);
    status_read_cmd(8'h05, 8'h00);
    cmd(8'h01, '0, 0, 8'hec, 1);
    chk("busy", 16'h0, busy);
    cmd(8'h06, '0, 0, '0, 0);
    cmd(8'h01, '0, 0, 8'hec, 1);
    chk("busy", 16'h1, busy);
    status_read_cmd(8'h05, 8'hff);
    cmd(8'h06, '0, 0, '0, 0);
    wait_idle();
    status_read_cmd(8'h05, 8'h8c);
    wp_n = 1'b0;
    cmd(8'h06, '0, 0, '0, 0);
    cmd(8'h01, '0, 0, 8'h00, 1);
    status_read_cmd(8'h05, 8'h8e);
    wp_n = 1'b1;
    $display("test status done");
  endtask
  task t_block();
    for (int l = 0; l < 5; l++) begin
      cmd(8'h06, '0, 0, '0, 0);
      cmd(8'h01, '0, 0, {4'h0, 2'(l), 2'h0}, 1);
      wait_idle();
      for (int k = 0; k < 3 && l < 4; k++) begin
        s = n_stb;
        cmd(8'h06, '0, 0, '0, 0);
        cmd(8'h02, pa[k], 2, 8'h3c, 1);
        chk("strobes", !(l == 3 || (l == 2 && pa[k][15]) || (l == 1 && pa[k][14] && pa[k][15])),
          n_stb - s);
        wait_idle();
      end
    end
    s = n_stb;
    g = n_go;
    cmd(8'h02, 16'h127e, 2, 8'ha0, 3);
    chk("strobes", 16'h0, n_stb - s);
    chk("launches", 16'h0, n_go - g);
    cmd(8'h06, '0, 0, '0, 0);
    cmd(8'h02, 16'h127e, 2, 8'ha0, 3);
    chk("strobes", 16'h3, n_stb - s);
    chk("launches", 16'h1, n_go - g);
    chk("last address", 16'h1200, saddr);
    chk("write data", 16'h00a2, sdata);
    wait_idle();
    status_read_cmd(8'h05, 8'h00);
    $display("test protection done");
  endtask
  task t_read();
    m.open();
    m.xfer(8'h0b, rx);
    m.xfer(8'hff, rx);
    m.xfer(8'hfe, rx);
    for (int k = 0; k < 3; k++) begin
      m.xfer(8'h00, rx, k == 1 ? 4 : -1);
      chk("read data", rd(16'hfffe + 16'(k)), rx);
    end
    m.close();
    m.mode3(1'b1);
    status_read_cmd(8'h05, 8'h00);
    m.mode3(1'b0);
    $display("test read done");
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    t_status();
    t_block();
    t_read();
    end_of_test();
  end
endmodule // spep_top_tb
